/* File: hdl/acl_l4_ethertype_matcher.sv */
// one access control entry: port, tcp flag and ethertype matching
//
// Functional notes
// (R1) source port modes: any, exact, range
// (R2) exact source port equals configured value
// (R3) source port range match within bounds
// (R4) same three destination modes; any ignores
// (R5) exact destination port equality match
// (R6) destination port within configured bounds
// (R7) fin condition: clear, set or any
// (R8) syn condition: clear, set or any
// (R9) rst condition: clear, set or any
// (R10) psh condition: clear, set or any
// (R11) ack condition: clear, set or any
// (R12) urg condition: clear, set or any
// (R13) ethertype only for ethertype class entries
// (R14) ethertype filter any or specific value
// (R15) specific ethertype limited to 0x600..0xFFFF
// (R16) software avoids ipv4, arp, ipv6 codes
// (R17) hit needs all criteria at once
// (R18) inclusive ranges; flags only for tcp
`timescale 1ns/1ps
`default_nettype none
`include "acl_match_defs.svh"

module acl_l4_ethertype_matcher
	import acl_match_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        reset,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata_ff,
	input  wire logic        frame_valid,
	input  wire frame_hdr_t  frame_hdr,
	output logic             result_valid_ff,
	output match_res_t       result_ff
);

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	port_mode_t   src_mode_ff, nxt_src_mode;
	port_mode_t   dst_mode_ff, nxt_dst_mode;
	logic [15:0]  src_lo_ff, nxt_src_lo, src_hi_ff, nxt_src_hi;
	logic [15:0]  dst_lo_ff, nxt_dst_lo, dst_hi_ff, nxt_dst_hi;
	logic [11:0]  flags_ff, nxt_flags;
	frame_class_t class_ff, nxt_class;
	logic         eth_spec_ff, nxt_eth_spec;
	logic [15:0]  eth_val_ff, nxt_eth_val;
	logic         eth_rej_ff, nxt_eth_rej;
	logic [31:0]  hit_cnt_ff, nxt_hit_cnt;
	logic [31:0]  nxt_rdata;

	// a code outside the allowed set is refused, the old value stays
	function automatic logic eth_allowed(input logic [15:0] v);
		eth_allowed = (v >= `ETH_MIN_TYPE) && (v != `ETH_IPV4) && //(R15)
			(v != `ETH_ARP) && (v != `ETH_IPV6); //(R16)
	endfunction

	function automatic port_mode_t to_mode(input logic [1:0] v);
		case (v)
			2'b01:   to_mode = PORT_EXACT;
			2'b10:   to_mode = PORT_RANGE;
			default: to_mode = PORT_ANY;
		endcase
	endfunction

	always_comb begin
		nxt_src_mode = src_mode_ff;
		nxt_dst_mode = dst_mode_ff;
		nxt_src_lo   = src_lo_ff;
		nxt_src_hi   = src_hi_ff;
		nxt_dst_lo   = dst_lo_ff;
		nxt_dst_hi   = dst_hi_ff;
		nxt_flags    = flags_ff;
		nxt_class    = class_ff;
		nxt_eth_spec = eth_spec_ff;
		nxt_eth_val  = eth_val_ff;
		nxt_eth_rej  = eth_rej_ff;
		if (reg_wr) begin
			case (reg_addr)
				`ADDR_SRC_CTRL: nxt_src_mode = to_mode(reg_wdata[1:0]); //(R1)
				`ADDR_SRC_LO:   nxt_src_lo = reg_wdata[15:0]; //(R2)
				`ADDR_SRC_HI:   nxt_src_hi = reg_wdata[15:0]; //(R3)
				`ADDR_DST_CTRL: nxt_dst_mode = to_mode(reg_wdata[1:0]); //(R4)
				`ADDR_DST_LO:   nxt_dst_lo = reg_wdata[15:0]; //(R5)
				`ADDR_DST_HI:   nxt_dst_hi = reg_wdata[15:0]; //(R6)
				`ADDR_FLAGS:    nxt_flags = reg_wdata[11:0];
				`ADDR_ETH_CTRL: begin
					nxt_eth_spec = reg_wdata[0]; //(R14)
					case (reg_wdata[5:4])
						2'b01:   nxt_class = CLASS_ETYPE;
						2'b10:   nxt_class = CLASS_IP;
						default: nxt_class = CLASS_ANY;
					endcase
				end
				`ADDR_ETH_VALUE: begin
					if (eth_allowed(reg_wdata[15:0])) begin
						nxt_eth_val = reg_wdata[15:0]; //(R15)
						nxt_eth_rej = 1'b0;
					end else begin
						nxt_eth_rej = 1'b1;
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			src_mode_ff <= PORT_ANY;
			dst_mode_ff <= PORT_ANY;
			src_lo_ff   <= 16'h0000;
			src_hi_ff   <= `RST_PORT_HI;
			dst_lo_ff   <= 16'h0000;
			dst_hi_ff   <= `RST_PORT_HI;
			flags_ff    <= {6{`RST_FLAG_COND}};
			class_ff    <= CLASS_ANY;
			eth_spec_ff <= 1'b0;
			eth_val_ff  <= `ETH_MIN_TYPE;
			eth_rej_ff  <= 1'b0;
		end else begin
			src_mode_ff <= nxt_src_mode;
			dst_mode_ff <= nxt_dst_mode;
			src_lo_ff   <= nxt_src_lo;
			src_hi_ff   <= nxt_src_hi;
			dst_lo_ff   <= nxt_dst_lo;
			dst_hi_ff   <= nxt_dst_hi;
			flags_ff    <= nxt_flags;
			class_ff    <= nxt_class;
			eth_spec_ff <= nxt_eth_spec;
			eth_val_ff  <= nxt_eth_val;
			eth_rej_ff  <= nxt_eth_rej;
		end
	end

	// ----------------------------------------------------------------
	// match stage one: per-criterion results, registered
	// ----------------------------------------------------------------
	logic        src_ok_ff, dst_ok_ff;
	logic        flags_ok_ff, nxt_flags_ok;
	logic        eth_ok_ff, nxt_eth_ok;
	logic        stage_ff, nxt_stage;

	port_cmp u_src_cmp (
		.sys_clk (sys_clk),
		.reset   (reset),
		.mode    (src_mode_ff), //(R1)
		.lo      (src_lo_ff),
		.hi      (src_hi_ff),
		.port    (frame_hdr.src_port),
		.ok_ff   (src_ok_ff)
	);

	port_cmp u_dst_cmp (
		.sys_clk (sys_clk),
		.reset   (reset),
		.mode    (dst_mode_ff), //(R4)
		.lo      (dst_lo_ff),
		.hi      (dst_hi_ff),
		.port    (frame_hdr.dst_port),
		.ok_ff   (dst_ok_ff)
	);

	function automatic logic flag_ok(input logic [1:0] cond,
			input logic bit_v);
		case (cond)
			FLAG_CLEAR: flag_ok = !bit_v;
			FLAG_SET:   flag_ok = bit_v;
			default:    flag_ok = 1'b1;
		endcase
	endfunction

	always_comb begin
		nxt_flags_ok = 1'b1;
		// non-tcp frames carry no flags, so the conditions do not apply
		if (frame_hdr.is_tcp) begin //(R18)
			for (int i = 0; i < 6; i++) begin
				if (!flag_ok(flags_ff[2*i +: 2], frame_hdr.tcp_flags[i]))
					nxt_flags_ok = 1'b0; //(R7) (R8) (R9) (R10) (R11) (R12)
			end
		end
		nxt_eth_ok = 1'b1;
		if (class_ff == CLASS_ETYPE && eth_spec_ff) //(R13)
			nxt_eth_ok = (frame_hdr.eth_type == eth_val_ff); //(R14)
		nxt_stage = frame_valid;
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			flags_ok_ff <= 1'b0;
			eth_ok_ff   <= 1'b0;
			stage_ff    <= 1'b0;
		end else begin
			flags_ok_ff <= nxt_flags_ok;
			eth_ok_ff   <= nxt_eth_ok;
			stage_ff    <= nxt_stage;
		end
	end

	// ----------------------------------------------------------------
	// match stage two: combine into hit, count hits
	// ----------------------------------------------------------------
	logic        nxt_res_valid;
	match_res_t  nxt_result;
	logic        all_ok;

	always_comb begin
		all_ok = src_ok_ff && dst_ok_ff && flags_ok_ff && eth_ok_ff; //(R17)
		nxt_res_valid = stage_ff;
		nxt_result = result_ff;
		nxt_hit_cnt = hit_cnt_ff;
		if (stage_ff) begin
			nxt_result.hit      = all_ok; //(R17)
			nxt_result.src_ok   = src_ok_ff;
			nxt_result.dst_ok   = dst_ok_ff;
			nxt_result.flags_ok = flags_ok_ff;
			nxt_result.eth_ok   = eth_ok_ff;
			if (all_ok)
				nxt_hit_cnt = hit_cnt_ff + 32'h0000_0001;
		end
		// a clear in the same cycle as a hit keeps that hit counted
		if (reg_wr && reg_addr == `ADDR_HIT_COUNT)
			nxt_hit_cnt = (stage_ff && all_ok) ? 32'h0000_0001 : 32'h0;
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			result_valid_ff <= 1'b0;
			result_ff       <= '0;
			hit_cnt_ff      <= 32'h0;
		end else begin
			result_valid_ff <= nxt_res_valid;
			result_ff       <= nxt_result;
			hit_cnt_ff      <= nxt_hit_cnt;
		end
	end

	// ----------------------------------------------------------------
	// register read port
	// ----------------------------------------------------------------
	always_comb begin
		nxt_rdata = 32'h0;
		if (reg_rd) begin
			case (reg_addr)
				`ADDR_SRC_CTRL:  nxt_rdata = {30'h0, src_mode_ff};
				`ADDR_SRC_LO:    nxt_rdata = {16'h0, src_lo_ff};
				`ADDR_SRC_HI:    nxt_rdata = {16'h0, src_hi_ff};
				`ADDR_DST_CTRL:  nxt_rdata = {30'h0, dst_mode_ff};
				`ADDR_DST_LO:    nxt_rdata = {16'h0, dst_lo_ff};
				`ADDR_DST_HI:    nxt_rdata = {16'h0, dst_hi_ff};
				`ADDR_FLAGS:     nxt_rdata = {20'h0, flags_ff};
				`ADDR_ETH_CTRL:  nxt_rdata = {26'h0, class_ff, 3'h0,
					eth_spec_ff};
				`ADDR_ETH_VALUE: nxt_rdata = {16'h0, eth_val_ff};
				`ADDR_STATUS:    nxt_rdata = {30'h0, eth_rej_ff,
					result_ff.hit};
				`ADDR_HIT_COUNT: nxt_rdata = hit_cnt_ff;
				default:         nxt_rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			reg_rdata_ff <= 32'h0;
		else
			reg_rdata_ff <= nxt_rdata;
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_hit_needs_all: assert property (@(posedge sys_clk) disable iff (reset) //(R17)
		result_valid_ff && result_ff.hit |-> result_ff.src_ok &&
		result_ff.dst_ok && result_ff.flags_ok && result_ff.eth_ok)
		else $error("hit without all criteria");

	a_result_latency: assert property (@(posedge sys_clk) disable iff (reset) //(R17)
		frame_valid |-> ##2 result_valid_ff)
		else $error("result not two cycles after frame");

	a_src_exact: assert property (@(posedge sys_clk) disable iff (reset) //(R2)
		frame_valid && src_mode_ff == PORT_EXACT && reg_wr == 1'b0
		|=> src_ok_ff == ($past(frame_hdr.src_port) == src_lo_ff))
		else $error("source exact compare wrong");

	a_dst_range: assert property (@(posedge sys_clk) disable iff (reset) //(R6)
		frame_valid && dst_mode_ff == PORT_RANGE && !reg_wr
		|=> dst_ok_ff == ($past(frame_hdr.dst_port) >= dst_lo_ff &&
		$past(frame_hdr.dst_port) <= dst_hi_ff))
		else $error("destination range compare wrong");

	a_src_any: assert property (@(posedge sys_clk) disable iff (reset) //(R1)
		frame_valid && src_mode_ff == PORT_ANY |=> src_ok_ff)
		else $error("source any must pass");

	a_flags_non_tcp: assert property (@(posedge sys_clk) disable iff (reset) //(R18)
		frame_valid && !frame_hdr.is_tcp |=> flags_ok_ff)
		else $error("flags checked on non tcp frame");

	a_fin_clear: assert property (@(posedge sys_clk) disable iff (reset) //(R7)
		frame_valid && frame_hdr.is_tcp && frame_hdr.tcp_flags[`FLAG_FIN]
		&& flags_ff[1:0] == FLAG_CLEAR |=> !flags_ok_ff)
		else $error("fin set frame passed clear condition");

	a_eth_class_only: assert property (@(posedge sys_clk) disable iff (reset) //(R13)
		frame_valid && class_ff != CLASS_ETYPE |=> eth_ok_ff)
		else $error("ethertype applied to other class");

	a_eth_value_legal: assert property (@(posedge sys_clk) disable iff (reset) //(R15)
		reg_wr && reg_addr == `ADDR_ETH_VALUE && !eth_allowed(reg_wdata[15:0])
		|=> eth_rej_ff && eth_val_ff == $past(eth_val_ff))
		else $error("illegal ethertype accepted");

endmodule

`default_nettype wire

/* File: hdl/acl_match_defs.svh */
// constants for the access control entry matcher
`ifndef ACL_MATCH_DEFS_SVH
`define ACL_MATCH_DEFS_SVH

`define ADDR_SRC_CTRL     8'h00
`define ADDR_SRC_LO       8'h04
`define ADDR_SRC_HI       8'h08
`define ADDR_DST_CTRL     8'h0C
`define ADDR_DST_LO       8'h10
`define ADDR_DST_HI       8'h14
`define ADDR_FLAGS        8'h18
`define ADDR_ETH_CTRL     8'h1C
`define ADDR_ETH_VALUE    8'h20
`define ADDR_STATUS       8'h24
`define ADDR_HIT_COUNT    8'h28

`define ETH_MIN_TYPE      16'h0600
`define ETH_IPV4          16'h0800
`define ETH_ARP           16'h0806
`define ETH_IPV6          16'h86DD

`define FLAG_FIN          0
`define FLAG_SYN          1
`define FLAG_RST          2
`define FLAG_PSH          3
`define FLAG_ACK          4
`define FLAG_URG          5

`define RST_PORT_MODE     2'h0
`define RST_FLAG_COND     2'h2
`define RST_PORT_HI       16'hFFFF

`endif

/* File: hdl/acl_match_pkg.sv */
// types for the access control entry matcher
package acl_match_pkg;

	typedef enum logic [1:0] {
		PORT_ANY   = 2'b00,
		PORT_EXACT = 2'b01,
		PORT_RANGE = 2'b10
	} port_mode_t;

	typedef enum logic [1:0] {
		FLAG_CLEAR = 2'b00,
		FLAG_SET   = 2'b01,
		FLAG_ANY   = 2'b10
	} flag_cond_t;

	typedef enum logic [1:0] {
		CLASS_ANY   = 2'b00,
		CLASS_ETYPE = 2'b01,
		CLASS_IP    = 2'b10
	} frame_class_t;

	typedef struct packed {
		logic [15:0] src_port;
		logic [15:0] dst_port;
		logic [15:0] eth_type;
		logic [5:0]  tcp_flags;
		logic        is_tcp;
		logic        is_l4;
	} frame_hdr_t;

	typedef struct packed {
		logic        hit;
		logic        src_ok;
		logic        dst_ok;
		logic        flags_ok;
		logic        eth_ok;
	} match_res_t;

endpackage

/* File: hdl/port_cmp.sv */
// port comparator: any, exact value or inclusive range
`timescale 1ns/1ps
`default_nettype none

module port_cmp
	import acl_match_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       reset,
	input  wire port_mode_t mode,
	input  wire logic [15:0] lo,
	input  wire logic [15:0] hi,
	input  wire logic [15:0] port,
	output logic            ok_ff
);

	logic nxt_ok;

	always_comb begin
		case (mode)
			PORT_ANY:   nxt_ok = 1'b1;
			PORT_EXACT: nxt_ok = (port == lo); //(R2) (R5)
			PORT_RANGE: nxt_ok = (port >= lo) && (port <= hi); //(R18)
			default:    nxt_ok = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			ok_ff <= 1'b0;
		else
			ok_ff <= nxt_ok;
	end

endmodule

`default_nettype wire

/* File: dv/frame_src.sv */
// receive path model: presents parsed frame headers one per cycle
`timescale 1ns/1ps
`default_nettype none

module frame_src
	import acl_match_pkg::*;
(
	input  wire logic sys_clk,
	output logic      frame_valid,
	output frame_hdr_t frame_hdr
);
	frame_hdr_t q[$];

	task automatic push(input frame_hdr_t h);
		q.push_back(h);
	endtask

	initial begin
		frame_valid = 1'b0;
		frame_hdr   = '0;
	end

	// idle header is scrambled so a stale sample cannot pass for a frame
	always @(posedge sys_clk) begin
		if (q.size() > 0) begin
			frame_valid <= 1'b1;
			frame_hdr   <= q.pop_front();
		end else begin
			frame_valid <= 1'b0;
			frame_hdr   <= ~frame_hdr;
		end
	end
endmodule
`default_nettype wire

/* File: dv/acl_l4_ethertype_matcher_bench.sv */
// self-checking bench for the access control entry matcher
`timescale 1ns/1ps
`default_nettype none
`include "acl_match_defs.svh"

module acl_l4_ethertype_matcher_bench
	import acl_match_pkg::*;
;
	logic        sys_clk, reset, reg_wr, reg_rd, frame_valid;
	logic        result_valid_ff, spec, v0, v1, v2;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata_ff, d;
	frame_hdr_t  frame_hdr, h;
	match_res_t  result_ff, e0, e1, e2;
	logic [1:0]  sm, dm, cls;
	logic [15:0] slo, shi, dlo, dhi, ev;
	logic [11:0] fl;
	int          n_fail, checks, cyc, n_hits;
	logic [7:0]  ra[11] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
		8'h18, 8'h1C, 8'h20, 8'h28, 8'h30};
	logic [31:0] rv[11] = '{32'h0, 32'h0, 32'hFFFF, 32'h0, 32'h0,
		32'hFFFF, 32'hAAA, 32'h0, 32'h600, 32'h0, 32'h0};
	logic [15:0] bad[4] = '{16'h0800, 16'h0806, 16'h86DD, 16'h05FF};

	acl_l4_ethertype_matcher u_acl_l4_ethertype_matcher (.sys_clk(sys_clk),
		.reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
		.frame_valid(frame_valid), .frame_hdr(frame_hdr),
		.result_valid_ff(result_valid_ff), .result_ff(result_ff));
	frame_src u_frame_src (.sys_clk(sys_clk), .frame_valid(frame_valid),
		.frame_hdr(frame_hdr));

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// ----------------------------------------
	// reference model
	// ----------------------------------------
	function automatic logic port_ok(logic [1:0] m, logic [15:0] lo, hi, p);
		return (m == 2'h1) ? (p == lo) : (m == 2'h2) ? (p >= lo && p <= hi) : 1'b1;
	endfunction

	function automatic match_res_t model(frame_hdr_t x);
		match_res_t r;
		r.flags_ok = 1'b1;
		// settings 0 and 1 name the value the flag must carry; tcp only
		for (int i = 0; i < 6; i++)
			if (x.is_tcp && !fl[2*i+1] && fl[2*i] != x.tcp_flags[i])
				r.flags_ok = 1'b0;
		r.src_ok = port_ok(sm, slo, shi, x.src_port);
		r.dst_ok = port_ok(dm, dlo, dhi, x.dst_port);
		r.eth_ok = !(cls == 2'h1 && spec) || x.eth_type == ev;
		r.hit    = r.flags_ok && r.src_ok && r.dst_ok && r.eth_ok;
		return r;
	endfunction

	// boundary values are favoured so off-by-one range slips show up
	function automatic logic [15:0] pick(logic [15:0] lo, hi);
		case ($urandom % 5)
			0: return lo;
			1: return hi;
			2: return lo - 16'h1;
			3: return hi + 16'h1;
			default: return 16'($urandom);
		endcase
	endfunction

	// ----------------------------------------
	// bus and check tasks
	// ----------------------------------------
	task automatic chk(input string n, input logic [31:0] s, e);
		checks++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] w);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= w;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 q = reg_rdata_ff;
		@(posedge sys_clk);
		#1 chk("rdata_idle", reg_rdata_ff, 32'h0);
	endtask

	task automatic complete_run;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// result arrives two edges after the frame edge
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 50000) begin
			n_fail++;
			complete_run;
		end
		// shift first: the frame seen two edges back is due at this edge
		v2 = v1;
		e2 = e1;
		v1 = v0;
		e1 = e0;
		if (!reset) begin
			chk("result_valid", {31'h0, result_valid_ff}, {31'h0, v2});
			if (v2) chk("result", {27'h0, result_ff}, {27'h0, e2});
		end
		v0 = frame_valid && !reset;
		e0 = model(frame_hdr);
		if (v0 && e0.hit) n_hits++;
	end

	initial begin
		n_fail = 0; checks = 0; cyc = 0; n_hits = 0;
		reset = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0;
		reg_addr = 8'h00; reg_wdata = 32'h0;
		v0 = 1'b0; v1 = 1'b0; v2 = 1'b0;
		sm = 2'h0; dm = 2'h0; slo = 16'h0; shi = 16'hFFFF; dlo = 16'h0;
		dhi = 16'hFFFF; fl = 12'hAAA; cls = 2'h0; spec = 1'b0; ev = 16'h0600;
		void'($urandom(94));
		repeat (8) @(posedge sys_clk);
		reset <= 1'b0;
		foreach (ra[i]) begin
			rd(ra[i], d);
			chk("reset_value", d, rv[i]);
		end
		wr(`ADDR_ETH_VALUE, 32'h1234);
		rd(`ADDR_STATUS, d);
		chk("status_reject", d & 32'h2, 32'h0);
		foreach (bad[i]) begin
			wr(`ADDR_ETH_VALUE, {16'h0, bad[i]});
			rd(`ADDR_STATUS, d);
			chk("status_reject", d & 32'h2, 32'h2);
			rd(`ADDR_ETH_VALUE, d);
			chk("eth_value", d, 32'h1234);
		end
		wr(`ADDR_ETH_VALUE, 32'hFFFF);
		rd(`ADDR_ETH_VALUE, d);
		chk("eth_value", d, 32'hFFFF);
		ev = 16'hFFFF;
		for (int it = 0; it < 150; it++) begin
			sm = $urandom % 4; dm = $urandom % 4; fl = $urandom;
			cls = $urandom % 4; spec = $urandom;
			slo = $urandom; shi = slo + 16'($urandom % 64);
			dlo = $urandom; dhi = dlo + 16'($urandom % 64);
			do ev = $urandom; while (ev < 16'h0600 || ev == 16'h0800 ||
				ev == 16'h0806 || ev == 16'h86DD);
			wr(`ADDR_SRC_CTRL, {30'h0, sm});
			wr(`ADDR_SRC_LO, {16'h0, slo});
			wr(`ADDR_SRC_HI, {16'h0, shi});
			wr(`ADDR_DST_CTRL, {30'h0, dm});
			wr(`ADDR_DST_LO, {16'h0, dlo});
			wr(`ADDR_DST_HI, {16'h0, dhi});
			wr(`ADDR_FLAGS, {20'h0, fl});
			wr(`ADDR_ETH_CTRL, {26'h0, cls, 3'h0, spec});
			wr(`ADDR_ETH_VALUE, {16'h0, ev});
			wr(`ADDR_HIT_COUNT, 32'h0);
			n_hits = 0;
			for (int k = 0; k < 8; k++) begin
				h.src_port = pick(slo, shi);
				h.dst_port = pick(dlo, dhi);
				h.eth_type = ($urandom % 2) ? ev : 16'($urandom);
				h.tcp_flags = $urandom;
				h.is_tcp = $urandom;
				h.is_l4 = 1'b1;
				u_frame_src.push(h);
			end
			repeat (12) @(posedge sys_clk);
			rd(`ADDR_HIT_COUNT, d);
			chk("hit_count", d, n_hits);
		end
		complete_run;
	end
endmodule
`default_nettype wire
